// ===== fbmc_cycle.sv
// One bus cycle on the flash pins: read or write strobe.
`timescale 1ns/10ps
`default_nettype none
module fbmc_cycle (
	input  wire logic        clk_i,    // System clock.
	input  wire logic        rst_i,    // Synchronous reset.
	input  wire logic        start_i,  // Start one cycle.
	input  wire logic        write_i,  // One for a write, zero for a read.
	input  wire logic [14:0] addr_i,   // Address for the cycle.
	input  wire logic [7:0]  wdata_i,  // Write data.
	input  wire logic [7:0]  dq_sync_i,// Synchronised data lines.
	input  wire logic [7:0]  hold_i,   // Cycles the active phase lasts.
	output logic             done_o,   // One-cycle pulse at the end.
	output logic [7:0]       rdata_o,  // Captured read data.
	output logic             sel_n_o,  // Chip select, low active.
	output logic             gate_n_o, // Output gate, low active.
	output logic             wstb_n_o, // Write strobe, low active.
	output logic [14:0]      addr_o,   // Address lines.
	output logic [7:0]       dq_o,     // Data driven in writes.
	output logic             dq_oe_o   // High while the data lines are driven.
);
	typedef enum logic [1:0] {
		FC_IDLE   = 2'b00,
		FC_SETUP  = 2'b01,
		FC_ACTIVE = 2'b10,
		FC_HOLD   = 2'b11
	} fbmc_cyc_state_t;

	typedef struct packed {
		fbmc_cyc_state_t st;
		logic [7:0]      cnt;
		logic            wr;
		logic            done;
		logic [7:0]      rdata;
		logic            sel_n;
		logic            gate_n;
		logic            wstb_n;
		logic [14:0]     addr;
		logic [7:0]      dq;
		logic            dq_oe;
	} fbmc_cyc_t;

	fbmc_cyc_t r;
	fbmc_cyc_t next_r;

	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		case (r.st)
			FC_IDLE: begin
				if (start_i) begin
					// Address and data are set up before any strobe falls.
					next_r.st = FC_SETUP;
					next_r.wr = write_i;
					next_r.addr = addr_i;
					next_r.dq = wdata_i;
					next_r.dq_oe = write_i;
					next_r.cnt = hold_i;
				end
			end
			FC_SETUP: begin
				next_r.st = FC_ACTIVE;
				next_r.sel_n = 1'b0;
				next_r.gate_n = r.wr;
				next_r.wstb_n = ~r.wr;
			end
			FC_ACTIVE: begin
				if (r.cnt <= 8'h01) begin
					next_r.st = FC_HOLD;
					if (!r.wr) begin
						next_r.rdata = dq_sync_i;
					end
					// Data stays driven past the rising strobe edge so the byte latches.
					next_r.wstb_n = 1'b1;
					next_r.gate_n = 1'b1;
					next_r.sel_n = 1'b1;
				end else begin
					next_r.cnt = r.cnt - 8'h01;
				end
			end
			FC_HOLD: begin
				next_r.st = FC_IDLE;
				next_r.dq_oe = 1'b0;
				next_r.done = 1'b1;
			end
			default: begin
				next_r.st = FC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '{st: FC_IDLE, cnt: 8'h00, wr: 1'b0, done: 1'b0, rdata: 8'h00,
				sel_n: 1'b1, gate_n: 1'b1, wstb_n: 1'b1, addr: 15'h0000,
				dq: 8'h00, dq_oe: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	assign done_o = r.done;
	assign rdata_o = r.rdata;
	assign sel_n_o = r.sel_n;
	assign gate_n_o = r.gate_n;
	assign wstb_n_o = r.wstb_n;
	assign addr_o = r.addr;
	assign dq_o = r.dq;
	assign dq_oe_o = r.dq_oe;

	a_no_drive_read: assert property (@(posedge clk_i) disable iff (rst_i)
		!(r.dq_oe && !r.gate_n)) else $error("data driven while gate low");
	a_write_gate_high: assert property (@(posedge clk_i) disable iff (rst_i)
		!r.wstb_n |-> (r.gate_n && !r.sel_n)) else $error("bad write pin state");
	a_data_past_rise: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(r.wstb_n) |-> r.dq_oe) else $error("data dropped at strobe rise");
endmodule // fbmc_cycle
`default_nettype wire

// ===== fbmc_flash_model.sv
// Behavioural parallel flash that answers the host controller on its pins.
`timescale 1ns/10ps
`default_nettype none
module fbmc_flash_model #(
	parameter logic [7:0] MFR_ID = 8'h83, // Arbitrary value, odd parity.
	parameter logic [7:0] DEV_ID = 8'h07  // Arbitrary value, odd parity.
) (
	input  wire logic [14:0] addr_i,   // Address lines.
	input  wire logic [7:0]  dq_i,     // Resolved data lines.
	input  wire logic        sel_n_i,  // Chip select, low active.
	input  wire logic        gate_n_i, // Output gate, low active.
	input  wire logic        wstb_n_i, // Write strobe, low active.
	input  wire logic        supply_i, // Programming supply high.
	input  wire logic        id_lvl_i, // Identifier level on the mode line.
	output logic [7:0]       dq_o,     // Data driven by the flash.
	output logic             dq_oe_o   // High while the flash drives.
);
	logic [7:0]  mem [0:32767];
	logic [7:0]  cmd;
	logic [7:0]  last;
	logic [14:0] lat_a;
	logic        armed;
	logic        id_sel;
	initial begin
		for (int i = 0; i < 32768; i++)
			mem[i] = 8'(i * 7 + 3);
		cmd = 8'h00;
		last = 8'h00;
		armed = 1'b0;
	end
	assign id_sel = (id_lvl_i && !supply_i) || cmd == 8'h80 || cmd == 8'h90;
	assign dq_oe_o = !sel_n_i && !gate_n_i;
	// Released lines show the inverse of the last byte so a late sample cannot pass.
	assign dq_o = !dq_oe_o ? ~last : !id_sel ? mem[addr_i] :
		addr_i[14:1] != 14'h0 ? ~last : addr_i[0] ? DEV_ID : MFR_ID;
	always @(dq_o or dq_oe_o)
		if (dq_oe_o)
			last = dq_o;
	always @(posedge supply_i or negedge supply_i)
		cmd = 8'h00;
	// Address is taken at the later falling edge of strobe or select.
	always @(negedge wstb_n_i or negedge sel_n_i)
		if (!wstb_n_i && !sel_n_i && gate_n_i) begin
			lat_a = addr_i;
			armed = supply_i;
		end
	always @(posedge wstb_n_i or posedge sel_n_i)
		if (armed) begin
			armed = 1'b0;
			if (cmd == 8'h10 || cmd == 8'h50) begin
				mem[lat_a] = dq_i;
				cmd = 8'h00;
			end else if (cmd == 8'h30 && dq_i == 8'h30) begin
				for (int i = 0; i < 32768; i++)
					mem[i] = 8'hFF;
				cmd = 8'h00;
			end else begin
				cmd = dq_i == 8'hFF ? 8'h00 : dq_i;
			end
		end
endmodule // fbmc_flash_model
`default_nettype wire

// ===== fbmc_host.sv
// Host controller that drives a parallel flash through its bus pins.
//
// Summary of operation
// - Flash drives data only while select and gate are both low.
// - Identifier mode: mode line high, others low, index line picks byte.
// - Writes happen only with strobe and select low, gate high.
// - Identifier command, either code; address zero maker, one device.
// - Program: setup code, then target address and data byte.
// - Chip erase needs the erase code written twice.
//
// Implementation choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module fbmc_host (
	input  wire logic        clk_i,         // System clock, 50 MHz.
	input  wire logic        rst_i,         // Synchronous reset, active high.
	input  wire logic [3:0]  wb_adr_i,      // Wishbone byte address.
	input  wire logic [31:0] wb_dat_i,      // Wishbone write data.
	input  wire logic [3:0]  wb_sel_i,      // Wishbone byte selects.
	input  wire logic        wb_we_i,       // Wishbone write enable.
	input  wire logic        wb_cyc_i,      // Wishbone cycle.
	input  wire logic        wb_stb_i,      // Wishbone strobe.
	output logic [31:0]      wb_dat_o,      // Wishbone read data.
	output logic             wb_ack_o,      // Wishbone acknowledge.
	input  wire logic [7:0]  dq_i,          // Flash data lines in.
	output logic [7:0]       dq_o,          // Flash data lines out.
	output logic             dq_oe_o,       // High while host drives data.
	output logic [14:0]      addr_o,        // Flash address lines.
	output logic             sel_n_o,       // Chip select, low active.
	output logic             gate_n_o,      // Output gate, low active.
	output logic             wstb_n_o,      // Write strobe, low active.
	output logic             supply_high_o, // Request programming supply high.
	output logic             id_level_o     // Drive identifier level on mode line.
);
	typedef enum logic [2:0] {
		FH_IDLE   = 3'b000,
		FH_FIRST  = 3'b001,
		FH_SECOND = 3'b010,
		FH_SETTLE = 3'b011,
		FH_READ   = 3'b100,
		FH_END    = 3'b101
	} fbmc_host_state_t;

	typedef struct packed {
		fbmc_host_state_t st;
		logic [3:0]       op;
		logic [14:0]      addr;
		logic [7:0]       wdata;
		logic [7:0]       rdata;
		logic [7:0]       latch;
		logic [7:0]       cnt;
		logic             busy;
		logic             perr;
		logic             refused;
		logic             supply;
		logic             idpin;
		logic             ack;
		logic [31:0]      dat;
		logic             start;
		logic             cwr;
		logic [14:0]      caddr;
		logic [7:0]       cdata;
		logic [7:0]       dq_s1;
		logic [7:0]       dq_s2;
		logic             idlvl;
	} fbmc_host_t;

	fbmc_host_t r;
	fbmc_host_t next_r;
	logic       cyc_done;
	logic [7:0] cyc_rdata;

	// Odd parity check on an identifier byte.
	function automatic logic odd_parity(input logic [7:0] b);
		odd_parity = ^b;
	endfunction

	// Code for the first bus cycle of each command.
	function automatic logic [7:0] first_code(input logic [3:0] op);
		case (op)
			fbmc_pkg::OP_CMD_IDENT:   first_code = fbmc_pkg::CMD_IDENT_A;
			fbmc_pkg::OP_CMD_PROGRAM: first_code = fbmc_pkg::CMD_PROG_A;
			fbmc_pkg::OP_CMD_ERASE:   first_code = fbmc_pkg::CMD_ERASE;
			default:                  first_code = fbmc_pkg::CMD_READ_A;
		endcase
	endfunction

	function automatic logic is_cmd(input logic [3:0] op);
		is_cmd = (op >= fbmc_pkg::OP_WRITE) && (op <= fbmc_pkg::OP_CMD_RESET);
	endfunction

	// Commands that need a second write cycle on the flash pins.
	function automatic logic is_pair(input logic [3:0] op);
		is_pair = (op == fbmc_pkg::OP_CMD_PROGRAM) || (op == fbmc_pkg::OP_CMD_ERASE) ||
			(op == fbmc_pkg::OP_CMD_RESET);
	endfunction

	fbmc_cycle u_cycle (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.start_i   (r.start),
		.write_i   (r.cwr),
		.addr_i    (r.caddr),
		.wdata_i   (r.cdata),
		.dq_sync_i (r.dq_s2),
		.hold_i    (r.cwr ? fbmc_pkg::STROBE_CYC : fbmc_pkg::ACCESS_CYC),
		.done_o    (cyc_done),
		.rdata_o   (cyc_rdata),
		.sel_n_o   (sel_n_o),
		.gate_n_o  (gate_n_o),
		.wstb_n_o  (wstb_n_o),
		.addr_o    (addr_o),
		.dq_o      (dq_o),
		.dq_oe_o   (dq_oe_o)
	);

	always_comb begin
		next_r = r;
		next_r.start = 1'b0;
		next_r.dq_s1 = dq_i;
		next_r.dq_s2 = r.dq_s1;
		next_r.ack = 1'b0;
		if (wb_cyc_i && wb_stb_i && !r.ack) begin
			next_r.ack = 1'b1;
			next_r.dat = 32'h0000_0000;
			case (wb_adr_i)
				fbmc_pkg::REG_CTRL: begin
					next_r.dat = {25'h0, r.idpin, r.supply, r.busy, r.op};
					if (wb_we_i && wb_sel_i[0] && !r.busy) begin
						next_r.op = wb_dat_i[fbmc_pkg::CTRL_OP_LSB +: 4];
						next_r.supply = wb_dat_i[fbmc_pkg::CTRL_SUPPLY_BIT];
						next_r.idpin = wb_dat_i[fbmc_pkg::CTRL_IDPIN_BIT];
						if (wb_dat_i[fbmc_pkg::CTRL_GO_BIT]) begin
							next_r.busy = 1'b1;
							next_r.refused = 1'b0;
							next_r.perr = 1'b0;
							next_r.st = FH_FIRST;
						end
					end
				end
				fbmc_pkg::REG_ADDR: begin
					next_r.dat = {17'h0, r.addr};
					if (wb_we_i && !r.busy) begin
						if (wb_sel_i[0]) next_r.addr[7:0] = wb_dat_i[7:0];
						if (wb_sel_i[1]) next_r.addr[14:8] = wb_dat_i[14:8];
					end
				end
				fbmc_pkg::REG_DATA: begin
					next_r.dat = {16'h0000, r.rdata, r.wdata};
					if (wb_we_i && wb_sel_i[0] && !r.busy) next_r.wdata = wb_dat_i[7:0];
				end
				fbmc_pkg::REG_STAT: begin
					next_r.dat = {21'h0, r.latch, r.refused, r.perr, r.busy};
				end
				default: begin
					next_r.dat = 32'h0000_0000;
				end
			endcase
		end
		// The device forgets its command whenever the supply is not high.
		if (!r.supply) next_r.latch = fbmc_pkg::COMMAND_LATCH_RST;
		case (r.st)
			FH_IDLE: begin
			end
			FH_FIRST: begin
				if (is_cmd(r.op) && !r.supply) begin
					// Writes would be ignored at low supply, so refuse them here.
					next_r.refused = 1'b1;
					next_r.busy = 1'b0;
					next_r.st = FH_IDLE;
				end else if (r.op == fbmc_pkg::OP_ID_READ) begin
					next_r.st = FH_SETTLE;
					next_r.cnt = fbmc_pkg::ID_SETTLE_CYC;
				end else begin
					next_r.start = 1'b1;
					next_r.cwr = r.op != fbmc_pkg::OP_READ;
					next_r.caddr = r.addr;
					next_r.cdata = (r.op == fbmc_pkg::OP_WRITE) ? r.wdata : first_code(r.op);
					next_r.st = FH_SECOND;
				end
			end
			FH_SECOND: begin
				if (cyc_done) begin
					next_r.st = FH_END;
					if (!r.cwr) begin
						next_r.rdata = cyc_rdata;
					end else if (r.op != fbmc_pkg::OP_WRITE) begin
						next_r.latch = r.cdata;
						// The low count bit marks the second write of a pair, so a
						// data byte that equals a command code is not taken for one.
						if (is_pair(r.op) && !r.cnt[0]) begin
							next_r.start = 1'b1;
							next_r.cnt = 8'h01;
							next_r.st = FH_SECOND;
							if (r.op == fbmc_pkg::OP_CMD_PROGRAM) begin
								next_r.cdata = r.wdata;
							end
						end
					end
				end
			end
			FH_SETTLE: begin
				// The mode line must reach its level before the identifier byte is read.
				if (r.cnt == 8'h00) begin
					next_r.start = 1'b1;
					next_r.cwr = 1'b0;
					next_r.caddr = r.addr[0] ? fbmc_pkg::IDENT_DEV_ADDR : fbmc_pkg::IDENT_MFR_ADDR;
					next_r.st = FH_READ;
				end else begin
					next_r.cnt = r.cnt - 8'h01;
				end
			end
			FH_READ: begin
				if (cyc_done) begin
					next_r.rdata = cyc_rdata;
					next_r.perr = !odd_parity(cyc_rdata);
					next_r.st = FH_END;
				end
			end
			FH_END: begin
				// An erase or program keeps running in the flash after deselect.
				next_r.busy = 1'b0;
				next_r.cnt = 8'h00;
				next_r.st = FH_IDLE;
			end
			default: begin
				next_r.st = FH_IDLE;
			end
		endcase
		// The identifier level is registered so the pin never glitches between states.
		next_r.idlvl = next_r.idpin && (next_r.st == FH_SETTLE || next_r.st == FH_READ);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '{st: FH_IDLE, op: 4'h0, addr: 15'h0000, wdata: 8'h00, rdata: 8'h00,
				latch: fbmc_pkg::COMMAND_LATCH_RST, cnt: 8'h00, busy: 1'b0, perr: 1'b0,
				refused: 1'b0, supply: 1'b0, idpin: 1'b0, ack: 1'b0, dat: 32'h0000_0000,
				start: 1'b0, cwr: 1'b0, caddr: 15'h0000, cdata: 8'h00, dq_s1: 8'h00,
				dq_s2: 8'h00, idlvl: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	assign wb_dat_o = r.dat;
	assign wb_ack_o = r.ack;
	assign supply_high_o = r.supply;
	assign id_level_o = r.idlvl;

	// Steps of a two-write command: the first write ends, then the second starts.
	sequence s_first_write_done;
		r.st == FH_SECOND && cyc_done && r.cwr && is_pair(r.op) && !r.cnt[0];
	endsequence
	sequence s_second_write_start;
		r.st == FH_SECOND && r.start && r.cwr && r.cnt[0];
	endsequence

	a_refuse_low_supply: assert property (@(posedge clk_i) disable iff (rst_i)
		(r.st == FH_FIRST && is_cmd(r.op) && !r.supply) |=> (r.refused && !r.busy))
		else $error("command at low supply not refused");
	a_latch_reset_low: assert property (@(posedge clk_i) disable iff (rst_i)
		!r.supply |=> r.latch == fbmc_pkg::COMMAND_LATCH_RST) else $error("latch not cleared");
	a_no_write_low: assert property (@(posedge clk_i) disable iff (rst_i)
		(!r.supply && r.st == FH_FIRST) |=> !(r.start && r.cwr)) else $error("write at low supply");
	a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
		r.ack |=> !r.ack) else $error("ack held");
	a_id_settle: assert property (@(posedge clk_i) disable iff (rst_i)
		(r.st == FH_SETTLE && r.cnt == 8'h00) |=> (r.st == FH_READ && r.start))
		else $error("identifier read did not start");
	a_parity_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		(r.st == FH_READ && cyc_done) |=> r.perr == !(^r.rdata)) else $error("parity flag wrong");
	a_busy_clears: assert property (@(posedge clk_i) disable iff (rst_i)
		r.st == FH_END |=> !r.busy) else $error("busy stuck");
	a_ident_select: assert property (@(posedge clk_i) disable iff (rst_i)
		(r.st == FH_READ && r.start) |-> r.caddr[14:1] == 14'h0000)
		else $error("identifier address not low");
	a_pair_second_write: assert property (@(posedge clk_i) disable iff (rst_i)
		s_first_write_done |=> s_second_write_start) else $error("second command write missing");
	a_program_data: assert property (@(posedge clk_i) disable iff (rst_i)
		(r.st == FH_SECOND && r.start && r.cnt[0] && r.op == fbmc_pkg::OP_CMD_PROGRAM) |->
		(r.cdata == r.wdata && r.caddr == r.addr)) else $error("program byte or address wrong");
	a_busy_while_op: assert property (@(posedge clk_i) disable iff (rst_i)
		r.st != FH_IDLE |-> r.busy) else $error("operation running while not busy");
	a_id_level_state: assert property (@(posedge clk_i) disable iff (rst_i)
		id_level_o |-> (r.st == FH_SETTLE || r.st == FH_READ)) else $error("identifier level stray");
	a_idle_deselect: assert property (@(posedge clk_i) disable iff (rst_i)
		r.st == FH_IDLE |-> sel_n_o) else $error("flash selected while idle");
	a_addr_held: assert property (@(posedge clk_i) disable iff (rst_i)
		r.st == FH_SECOND |-> r.caddr == r.addr) else $error("command address not held");
	a_flags_fresh: assert property (@(posedge clk_i) disable iff (rst_i)
		r.st == FH_FIRST |-> (!r.perr && !r.refused)) else $error("stale status flags");
endmodule // fbmc_host
`default_nettype wire

// ===== fbmc_host_tb_top.sv
// Self-checking testbench of the flash host controller with a flash model.
`timescale 1ns/10ps
`default_nettype none
module fbmc_host_tb_top;
	localparam logic [7:0] MFR_ID = 8'h83; // Arbitrary value, odd parity.
	localparam logic [7:0] DEV_ID = 8'h07; // Arbitrary value, odd parity.
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [3:0]  wb_adr_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0]  wb_sel_i = 4'hF;
	logic        wb_we_i = 1'b0;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic [7:0]  dq_o;
	logic        dq_oe_o;
	logic [14:0] addr_o;
	logic        sel_n_o;
	logic        gate_n_o;
	logic        wstb_n_o;
	logic        supply_high_o;
	logic        id_level_o;
	logic [7:0]  f_q;
	logic        f_oe;
	wire logic [7:0] dq_bus;
	int          error_cnt = 0;
	int          check_count = 0;
	int          exp_mem[int];
	logic        erased = 1'b0;
	logic        supply = 1'b0;
	logic        idpin = 1'b0;
	logic [31:0] st;
	logic [7:0]  b;
	logic [14:0] a;
	logic [7:0]  d;
	assign dq_bus = dq_oe_o ? dq_o : f_q;
	always #10 clk_i = ~clk_i;
	fbmc_host uut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dq_i(dq_bus), .dq_o(dq_o),
		.dq_oe_o(dq_oe_o), .addr_o(addr_o), .sel_n_o(sel_n_o), .gate_n_o(gate_n_o),
		.wstb_n_o(wstb_n_o), .supply_high_o(supply_high_o), .id_level_o(id_level_o));
	fbmc_flash_model #(.MFR_ID(MFR_ID), .DEV_ID(DEV_ID)) flash (.addr_i(addr_o),
		.dq_i(dq_bus), .sel_n_i(sel_n_o), .gate_n_i(gate_n_o), .wstb_n_i(wstb_n_o),
		.supply_i(supply_high_o), .id_lvl_i(id_level_o), .dq_o(f_q), .dq_oe_o(f_oe));
	task automatic complete_run;
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb_cycle(input logic [3:0] ad, input logic we, input logic [31:0] wd,
		output logic [31:0] rdat);
		@(posedge clk_i);
		wb_adr_i <= ad;
		wb_we_i <= we;
		wb_dat_i <= wd;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	// Loads address and data, starts the operation and polls busy to its end.
	task automatic flash_op(input logic [3:0] op, input logic [14:0] ad, input logic [7:0] wd);
		logic [31:0] q;
		wb_cycle(fbmc_pkg::REG_ADDR, 1'b1, 32'(ad), q);
		wb_cycle(fbmc_pkg::REG_DATA, 1'b1, 32'(wd), q);
		wb_cycle(fbmc_pkg::REG_CTRL, 1'b1, {25'h0, idpin, supply, 1'b1, op}, q);
		st = 32'h1;
		while (st[fbmc_pkg::STAT_BUSY_BIT] !== 1'b0)
			wb_cycle(fbmc_pkg::REG_STAT, 1'b0, 32'h0, st);
	endtask
	task automatic rd(input logic [14:0] ad, input logic [3:0] op, output logic [7:0] v);
		logic [31:0] q;
		flash_op(op, ad, 8'h00);
		wb_cycle(fbmc_pkg::REG_DATA, 1'b0, 32'h0, q);
		v = q[15:8];
	endtask
	function automatic logic [7:0] exp_at(input logic [14:0] ad);
		if (exp_mem.exists(int'(ad)))
			return 8'(exp_mem[int'(ad)]);
		return erased ? 8'hFF : 8'(ad * 7 + 3);
	endfunction
	always @(posedge clk_i)
		if (!rst_i) begin
			check(32'(!wstb_n_o && (sel_n_o !== 1'b0 || gate_n_o !== 1'b1)), 32'h0);
			check(32'(dq_oe_o && f_oe), 32'h0);
			check(32'(id_level_o && supply_high_o), 32'h0);
		end
	initial begin
		repeat (60000) @(posedge clk_i);
		error_cnt++;
		$display("unexpected at %0t: run did not finish", $time);
		complete_run;
	end
	initial begin
		void'($urandom(46));
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check({sel_n_o, gate_n_o, wstb_n_o, dq_oe_o, supply_high_o}, 5'b11100);
		wb_cycle(fbmc_pkg::REG_STAT, 1'b0, 32'h0, st);
		check(st, 32'h0);
		for (int i = 0; i < 4; i++) begin
			a = 15'($urandom);
			rd(a, fbmc_pkg::OP_READ, b);
			check(b, exp_at(a));
		end
		idpin = 1'b1;
		for (int i = 0; i < 2; i++) begin
			rd(15'(i), fbmc_pkg::OP_ID_READ, b);
			check(b, i ? DEV_ID : MFR_ID);
			check(^b, 1'b1);
			check(st[fbmc_pkg::STAT_PERR_BIT], 1'b0);
		end
		idpin = 1'b0;
		flash_op(fbmc_pkg::OP_CMD_PROGRAM, a, 8'h00);
		check(st[fbmc_pkg::STAT_REFUSE_BIT], 1'b1);
		rd(a, fbmc_pkg::OP_READ, b);
		check(b, exp_at(a));
		supply = 1'b1;
		flash_op(fbmc_pkg::OP_CMD_IDENT, 15'($urandom), 8'h00);
		check(st[10:3], fbmc_pkg::CMD_IDENT_A);
		for (int i = 0; i < 2; i++) begin
			rd(15'(i), fbmc_pkg::OP_READ, b);
			check(b, i ? DEV_ID : MFR_ID);
		end
		flash_op(fbmc_pkg::OP_CMD_READ, 15'($urandom), 8'h00);
		rd(15'h0001, fbmc_pkg::OP_READ, b);
		check(b, exp_at(15'h0001));
		a = 15'($urandom);
		d = 8'($urandom);
		flash_op(fbmc_pkg::OP_CMD_PROGRAM, a, d);
		exp_mem[int'(a)] = int'(d);
		rd(a, fbmc_pkg::OP_READ, b);
		check(b, exp_at(a));
		flash_op(fbmc_pkg::OP_CMD_PROGRAM, a ^ 15'h0001, fbmc_pkg::CMD_PROG_A);
		exp_mem[int'(a ^ 15'h0001)] = int'(fbmc_pkg::CMD_PROG_A);
		rd(a ^ 15'h0001, fbmc_pkg::OP_READ, b);
		check(b, exp_at(a ^ 15'h0001));
		flash_op(fbmc_pkg::OP_WRITE, 15'($urandom), fbmc_pkg::CMD_ERASE);
		flash_op(fbmc_pkg::OP_CMD_RESET, 15'($urandom), 8'h00);
		rd(a, fbmc_pkg::OP_READ, b);
		check(b, exp_at(a));
		flash_op(fbmc_pkg::OP_CMD_IDENT, 15'h0000, 8'h00);
		supply = 1'b0;
		wb_cycle(fbmc_pkg::REG_CTRL, 1'b1, 32'h0, st);
		supply = 1'b1;
		rd(15'h0000, fbmc_pkg::OP_READ, b);
		check(b, exp_at(15'h0000));
		flash_op(fbmc_pkg::OP_CMD_ERASE, 15'($urandom), 8'h00);
		erased = 1'b1;
		exp_mem.delete();
		rd(a, fbmc_pkg::OP_READ, b);
		check(b, exp_at(a));
		complete_run;
	end
endmodule // fbmc_host_tb_top
`default_nettype wire

// ===== fbmc_pkg.sv
// Package of constants for the flash bus-mode host controller.
package fbmc_pkg;
	localparam logic [7:0]  CMD_READ_A      = 8'h00;
	localparam logic [7:0]  CMD_READ_B      = 8'hFF;
	localparam logic [7:0]  CMD_IDENT_A     = 8'h80;
	localparam logic [7:0]  CMD_IDENT_B     = 8'h90;
	localparam logic [7:0]  CMD_ERASE       = 8'h30;
	localparam logic [7:0]  CMD_PROG_A      = 8'h10;
	localparam logic [7:0]  CMD_PROG_B      = 8'h50;
	localparam logic [7:0]  COMMAND_LATCH_RST = 8'h00;
	localparam logic [14:0] IDENT_MFR_ADDR  = 15'h0000;
	localparam logic [14:0] IDENT_DEV_ADDR  = 15'h0001;
	// Wishbone register offsets (byte addresses).
	localparam logic [3:0]  REG_CTRL        = 4'h0;
	localparam logic [3:0]  REG_ADDR        = 4'h4;
	localparam logic [3:0]  REG_DATA        = 4'h8;
	localparam logic [3:0]  REG_STAT        = 4'hC;
	// Control register fields.
	localparam int          CTRL_OP_LSB     = 0;
	localparam int          CTRL_GO_BIT     = 4;
	localparam int          CTRL_SUPPLY_BIT = 5;
	localparam int          CTRL_IDPIN_BIT  = 6;
	// Operation codes written into the control register.
	localparam logic [3:0]  OP_READ         = 4'h0;
	localparam logic [3:0]  OP_WRITE        = 4'h1;
	localparam logic [3:0]  OP_CMD_READ     = 4'h2;
	localparam logic [3:0]  OP_CMD_IDENT    = 4'h3;
	localparam logic [3:0]  OP_CMD_PROGRAM  = 4'h4;
	localparam logic [3:0]  OP_CMD_ERASE    = 4'h5;
	localparam logic [3:0]  OP_CMD_RESET    = 4'h6;
	localparam logic [3:0]  OP_ID_READ      = 4'h7;
	// Bus timing: 20 ns clock; least times round up to whole cycles.
	localparam int          CLK_NS          = 20;
	localparam int          ACCESS_NS       = 200;
	localparam int          STROBE_NS       = 100;
	localparam int          ID_SETTLE_NS    = 500;
	localparam logic [7:0]  ACCESS_CYC      = 8'((ACCESS_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0]  STROBE_CYC      = 8'((STROBE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0]  ID_SETTLE_CYC   = 8'((ID_SETTLE_NS + CLK_NS - 1) / CLK_NS);
	// Status bits.
	localparam int          STAT_BUSY_BIT   = 0;
	localparam int          STAT_PERR_BIT   = 1;
	localparam int          STAT_REFUSE_BIT = 2;
endpackage
